// ==== include/eac_consts.vh ====
// Constants for the nonvolatile access controller
`ifndef EAC_CONSTS_VH
`define EAC_CONSTS_VH

// ==========================================================
// Register offsets
`define EAC_OFS_CTRL     3'h0
`define EAC_OFS_KEY      3'h1
`define EAC_OFS_DATL     3'h2
`define EAC_OFS_DATH     3'h3
`define EAC_OFS_ADRL     3'h4
`define EAC_OFS_ADRH     3'h5
`define EAC_OFS_FLAGS    3'h6

// ==========================================================
// Control register bit positions
`define EAC_BIT_RD       0
`define EAC_BIT_WR       1
`define EAC_BIT_WRITE_PERMIT     2
`define EAC_BIT_WRITE_ABORT_FLAG    3
`define EAC_BIT_CONFIG_SPACE_SELECT     6
`define EAC_BIT_PGD      7

// Flag register bit position
`define EAC_BIT_DONE     4

// ==========================================================
// Unlock key bytes
`define EAC_KEY1         8'h55
`define EAC_KEY2         8'hAA

// ==========================================================
// Timing
`define EAC_CLK_HZ       40000000
`define EAC_PWRT_MS      64
`define EAC_PWRT_CYC     ((`EAC_CLK_HZ / 1000) * `EAC_PWRT_MS)
`define EAC_WR_US        4000
`define EAC_WR_CYC       ((`EAC_CLK_HZ / 1000000) * `EAC_WR_US)
`define EAC_PRD_CYC      2

`endif

// ==== logic/eac_access_ctrl.v ====
// Indirect access controller for data and program nonvolatile memories
`timescale 1ns/1ps
`include "eac_consts.vh"

module eac_access_ctrl #(
	parameter PWRT_CYC = `EAC_PWRT_CYC,
	parameter WR_CYC   = `EAC_WR_CYC,
	parameter PAW      = 15,
	parameter PDW      = 14
)(
	// Clock and reset
	input  wire           sys_clk_i,
	input  wire           rst_i,
	input  wire           por_i,
	// Register port
	input  wire [2:0]     reg_addr_i,
	input  wire [7:0]     reg_wdata_i,
	input  wire           reg_wr_i,
	input  wire           reg_rd_i,
	output reg  [7:0]     reg_rdata_o,
	// Configuration
	input  wire [1:0]     self_write_protect_i,
	input  wire           data_protect_n_i,
	input  wire           program_protect_n_i,
	input  wire           prog_req_i,
	// Status
	output reg            write_busy_o,
	output reg            programmer_block_o
);

	// ==========================================================
	// Memories
	reg [7:0]     data_mem [0:255];
	reg [PDW-1:0] prog_mem [0:(1<<PAW)-1];

	// ==========================================================
	// Registers
	reg [7:0]  datl_r;
	reg [7:0]  dath_r;
	reg [7:0]  adrl_r;
	reg [7:0]  adrh_r;
	reg        pgd_r;
	reg        config_space_select_r;
	reg        write_permit_r;
	reg        write_abort_flag_r;
	reg        rd_r;
	reg        wr_r;
	reg        done_r;
	reg [1:0]  key_r;
	reg        pwrt_done_r;
	reg [31:0] pwrt_cnt_r;
	reg [31:0] wr_cnt_r;
	reg [1:0]  prd_cnt_r;
	reg        wr_pgd_r;
	reg [7:0]  rd_mux;

	// ==========================================================
	// Unlock key progress
	localparam [1:0] KEY_IDLE = 2'b00;
	localparam [1:0] KEY_HALF = 2'b01;
	localparam [1:0] KEY_OPEN = 2'b10;

	// Program read delay in cycles
	localparam [1:0] PRD_CYC  = `EAC_PRD_CYC;

	// ==========================================================
	// Decodes
	wire [PAW-1:0] paddr     = {adrh_r[PAW-9:0], adrl_r};
	wire [PDW-1:0] prog_word = prog_mem[paddr];
	wire           wr_ctrl   = reg_wr_i && (reg_addr_i == `EAC_OFS_CTRL);
	wire           wr_key    = reg_wr_i && (reg_addr_i == `EAC_OFS_KEY);
	wire           wr_datl   = reg_wr_i && (reg_addr_i == `EAC_OFS_DATL);
	wire           wr_dath   = reg_wr_i && (reg_addr_i == `EAC_OFS_DATH);
	wire           wr_adrl   = reg_wr_i && (reg_addr_i == `EAC_OFS_ADRL);
	wire           wr_adrh   = reg_wr_i && (reg_addr_i == `EAC_OFS_ADRH);
	wire           wr_flags  = reg_wr_i && (reg_addr_i == `EAC_OFS_FLAGS);
	wire           flag_clr  = wr_flags && !reg_wdata_i[`EAC_BIT_DONE];
	// Last timed cycle of a write
	wire           wr_finish = wr_r && (wr_cnt_r >= WR_CYC - 1);
	// Program word lands on this cycle
	wire           prog_rd_load = rd_r && (prd_cnt_r == 2'd1);
	// Either protect bit active locks out the external programmer
	wire           prot_any  = !data_protect_n_i || !program_protect_n_i;
	// Program self-write allowed unless protect is 00 (full protect)
	wire prog_wr_ok = (self_write_protect_i != 2'b00);
	wire space_ok = pgd_r ? prog_wr_ok : pwrt_done_r;
	wire wr_start = wr_ctrl && reg_wdata_i[`EAC_BIT_WR] && !wr_r
		&& write_permit_r && (key_r == KEY_OPEN)
		&& !config_space_select_r && space_ok;
	wire rd_start = wr_ctrl && reg_wdata_i[`EAC_BIT_RD] && !wr_r && !rd_r
		&& !reg_wdata_i[`EAC_BIT_CONFIG_SPACE_SELECT];

	// ==========================================================
	// Power-up timer, restarts only on power-on
	always @(posedge sys_clk_i)
	begin
		if (por_i)
			pwrt_cnt_r <= 32'h0;
		else if (!pwrt_done_r)
			pwrt_cnt_r <= pwrt_cnt_r + 32'h1;
	end

	// Data writes stay blocked until the count runs out
	always @(posedge sys_clk_i)
	begin
		if (por_i)
			pwrt_done_r <= 1'b0;
		else if (!pwrt_done_r && pwrt_cnt_r >= PWRT_CYC - 1)
			pwrt_done_r <= 1'b1;
	end

	// ==========================================================
	// Write permit: only power-on clears it in hardware
	always @(posedge sys_clk_i)
	begin
		if (por_i)
			write_permit_r <= 1'b0;
		else if (!rst_i && wr_ctrl)
			write_permit_r <= reg_wdata_i[`EAC_BIT_WRITE_PERMIT];
	end

	// ==========================================================
	// Abort flag: a general reset that cuts a write sets it
	always @(posedge sys_clk_i)
	begin
		if (por_i)
			write_abort_flag_r <= 1'b0;
		else if (rst_i)
		begin
			if (wr_r)
				write_abort_flag_r <= 1'b1;
		end
		else if (wr_ctrl)
			write_abort_flag_r <= reg_wdata_i[`EAC_BIT_WRITE_ABORT_FLAG];
	end

	// ==========================================================
	// Address holding registers
	always @(posedge sys_clk_i)
	begin
		if (rst_i || por_i)
		begin
			adrl_r <= 8'h00;
			adrh_r <= 8'h00;
		end
		else
		begin
			if (wr_adrl)
				adrl_r <= reg_wdata_i;
			// Upper bit beyond the 15-bit word address reads as zero
			if (wr_adrh)
				adrh_r <= {1'b0, reg_wdata_i[6:0]};
		end
	end

	// ==========================================================
	// Space selects, frozen while a write runs
	always @(posedge sys_clk_i)
	begin
		if (rst_i || por_i)
		begin
			pgd_r  <= 1'b0;
			config_space_select_r <= 1'b0;
		end
		else if (wr_ctrl && !wr_r)
		begin
			pgd_r  <= reg_wdata_i[`EAC_BIT_PGD];
			config_space_select_r <= reg_wdata_i[`EAC_BIT_CONFIG_SPACE_SELECT];
		end
	end

	// ==========================================================
	// Unlock key: any other register write breaks the sequence
	always @(posedge sys_clk_i)
	begin
		if (rst_i || por_i)
			key_r <= KEY_IDLE;
		// Each started write consumes the key pair
		else if (wr_start)
			key_r <= KEY_IDLE;
		else if (!wr_r)
		begin
			if (wr_key)
			begin
				if (reg_wdata_i == `EAC_KEY1)
					key_r <= KEY_HALF;
				else if (reg_wdata_i == `EAC_KEY2 && key_r == KEY_HALF)
					key_r <= KEY_OPEN;
				else
					key_r <= KEY_IDLE;
			end
			else if (reg_wr_i)
				key_r <= KEY_IDLE;
		end
	end

	// ==========================================================
	// Data holding registers: software loads, reads refill
	always @(posedge sys_clk_i)
	begin
		if (rst_i || por_i)
		begin
			datl_r <= 8'h00;
			dath_r <= 8'h00;
		end
		else if (rd_start && !reg_wdata_i[`EAC_BIT_PGD])
			datl_r <= data_mem[adrl_r];
		// A read result wins over a software load in one cycle
		else if (prog_rd_load)
		begin
			datl_r <= prog_word[7:0];
			dath_r <= {2'b00, prog_word[PDW-1:8]};
		end
		else
		begin
			if (wr_datl)
				datl_r <= reg_wdata_i;
			if (wr_dath)
				dath_r <= {2'b00, reg_wdata_i[5:0]};
		end
	end

	// ==========================================================
	// Program read sequencer
	always @(posedge sys_clk_i)
	begin
		if (rst_i || por_i)
		begin
			rd_r      <= 1'b0;
			prd_cnt_r <= 2'd0;
		end
		// The word is fetched in the second cycle after the strobe
		else if (rd_start && reg_wdata_i[`EAC_BIT_PGD])
		begin
			rd_r      <= 1'b1;
			prd_cnt_r <= PRD_CYC;
		end
		else if (rd_r)
		begin
			prd_cnt_r <= prd_cnt_r - 2'd1;
			if (prd_cnt_r == 2'd1)
				rd_r <= 1'b0;
		end
	end

	// ==========================================================
	// Write sequencer: set-only strobe, cleared by internal timer
	always @(posedge sys_clk_i)
	begin
		if (rst_i || por_i)
		begin
			wr_r     <= 1'b0;
			wr_cnt_r <= 32'h0;
			wr_pgd_r <= 1'b0;
		end
		// The target space is latched at start
		else if (wr_start)
		begin
			wr_r     <= 1'b1;
			wr_cnt_r <= 32'h0;
			wr_pgd_r <= pgd_r;
		end
		// No software clear, so a started write runs out unless a reset cuts it
		else if (wr_r)
		begin
			wr_cnt_r <= wr_cnt_r + 32'h1;
			if (wr_finish)
				wr_r <= 1'b0;
		end
	end

	// ==========================================================
	// Memory commit on the last timed cycle
	// Memories carry no reset; a cut write commits nothing
	always @(posedge sys_clk_i)
	begin
		if (!rst_i && !por_i && wr_finish)
		begin
			if (wr_pgd_r)
				prog_mem[paddr] <= {dath_r[5:0], datl_r};
			else
				data_mem[adrl_r] <= datl_r;
		end
	end

	// ==========================================================
	// Write done flag
	// A completing write wins over a software clear
	always @(posedge sys_clk_i)
	begin
		if (rst_i || por_i)
			done_r <= 1'b0;
		else if (wr_finish)
			done_r <= 1'b1;
		else if (flag_clr)
			done_r <= 1'b0;
	end

	// ==========================================================
	// Read-back mux
	always @*
	begin
		case (reg_addr_i)
			`EAC_OFS_CTRL:  rd_mux = {pgd_r, config_space_select_r, 2'b00, write_abort_flag_r,
				write_permit_r, wr_r, rd_r};
			`EAC_OFS_KEY:   rd_mux = 8'h00;
			`EAC_OFS_DATL:  rd_mux = datl_r;
			`EAC_OFS_DATH:  rd_mux = dath_r;
			`EAC_OFS_ADRL:  rd_mux = adrl_r;
			`EAC_OFS_ADRH:  rd_mux = adrh_r;
			`EAC_OFS_FLAGS: rd_mux = {3'b000, done_r, 4'h0};
			default:        rd_mux = 8'h00;
		endcase
	end

	// ==========================================================
	// Read data, one cycle after the read strobe
	// Zero when idle so stale data never shows
	always @(posedge sys_clk_i)
	begin
		if (rst_i || por_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
			reg_rdata_o <= rd_mux;
		else
			reg_rdata_o <= 8'h00;
	end

	// ==========================================================
	// Busy mirror of the write strobe
	always @(posedge sys_clk_i)
	begin
		if (rst_i || por_i)
			write_busy_o <= 1'b0;
		else
			write_busy_o <= wr_r;
	end

	// ==========================================================
	// External programmer locked out; CPU path unaffected
	always @(posedge sys_clk_i)
	begin
		if (rst_i || por_i)
			programmer_block_o <= 1'b0;
		else
			programmer_block_o <= prog_req_i && prot_any;
	end

endmodule

// ==== testbench/eac_props.sv ====
// Port-level properties of the access controller
`timescale 1ns/1ps
module eac_props #(
	parameter PWRT_CYC = 40,
	parameter WR_CYC = 5
)(
	// Design ports
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic data_protect_n_i,
	input wire logic program_protect_n_i,
	input wire logic prog_req_i,
	input wire logic write_busy_o,
	input wire logic programmer_block_o
);
	// ====
	// Properties
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i || por_i);
	wire lock = prog_req_i && !(data_protect_n_i && program_protect_n_i);
	sequence s_hold; write_busy_o [*3]; endsequence
	sequence s_end; ##[1:12] !write_busy_o; endsequence
	property p_key; reg_rd_i && reg_addr_i == 3'h1 |=> reg_rdata_o == 8'h00;
	endproperty
	a_key: assert property (p_key) else $error("key read");
	property p_rdz; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
	a_rdz: assert property (p_rdz) else $error("idle data");
	property p_dath; reg_rd_i && reg_addr_i == 3'h3 |=> !reg_rdata_o[7:6];
	endproperty
	a_dath: assert property (p_dath) else $error("word width");
	property p_flg; reg_rd_i && reg_addr_i == 3'h6 |=> !(reg_rdata_o & 8'hEF);
	endproperty
	a_flg: assert property (p_flg) else $error("flag bits");
	property p_pon; lock |=> programmer_block_o; endproperty
	a_pon: assert property (p_pon) else $error("no block");
	property p_poff; !lock |=> !programmer_block_o; endproperty
	a_poff: assert property (p_poff) else $error("block");
	property p_go; $rose(write_busy_o) |->
		$past(reg_wr_i && reg_addr_i == 3'h0 && reg_wdata_i[1], 2); endproperty
	a_go: assert property (p_go) else $error("start");
	property p_len; $rose(write_busy_o) |-> s_hold ##0 s_end; endproperty
	a_len: assert property (p_len) else $error("length");
endmodule
bind eac_access_ctrl eac_props #(.PWRT_CYC(PWRT_CYC), .WR_CYC(WR_CYC)) u_p(
	.sys_clk_i, .rst_i, .por_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
	.reg_rd_i, .reg_rdata_o, .data_protect_n_i, .program_protect_n_i,
	.prog_req_i, .write_busy_o, .programmer_block_o);

// ==== testbench/eac_cpu.sv ====
// Firmware bus master model for the access registers
`timescale 1ns/1ps
module eac_cpu(
	// Register port
	input wire logic clk_i,
	output logic [2:0] a_o,
	output logic [7:0] d_o,
	output logic w_o,
	output logic r_o,
	input wire logic [7:0] q_i
);
	logic [7:0] q;
	initial
	begin
		{a_o, d_o, w_o, r_o} = 13'h0000;
	end
	// ====
	// Bus cycles, released lines inverted
	task cyc(input [2:0] a, input [7:0] d, input rd);
		@(posedge clk_i);
		{a_o, d_o, w_o, r_o} <= {a, d, !rd, rd};
		@(posedge clk_i);
		{a_o, d_o, w_o, r_o} <= {~a, ~d, 2'b00};
		#1 q = q_i;
	endtask
	task wr(input [2:0] a, input [7:0] d);
		cyc(a, d, 1'b0);
	endtask
	// Unlock pair then start, interrupts assumed off
	task go(input [7:0] c);
		wr(3'h1, 8'h55);
		wr(3'h1, 8'hAA);
		wr(3'h0, c | 8'h02);
	endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the nonvolatile access controller
`timescale 1ns/1ps
module tb;
	logic sys_clk_i, rst_i, por_i, w, r, busy, pblk, req, dpn, ppn;
	logic [1:0] swp;
	logic [2:0] a;
	logic [7:0] d, q;
	int err_count, checks_done;
	eac_access_ctrl #(.PWRT_CYC(40), .WR_CYC(5)) dut(.sys_clk_i(sys_clk_i),
		.rst_i(rst_i), .por_i(por_i), .reg_addr_i(a), .reg_wdata_i(d),
		.reg_wr_i(w), .reg_rd_i(r), .reg_rdata_o(q),
		.self_write_protect_i(swp), .data_protect_n_i(dpn),
		.program_protect_n_i(ppn), .prog_req_i(req),
		.write_busy_o(busy), .programmer_block_o(pblk));
	eac_cpu cpu(.clk_i(sys_clk_i), .a_o(a), .d_o(d), .w_o(w), .r_o(r),
		.q_i(q));
	initial
	begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	// ====
	// Helpers
	task chk(input logic [7:0] g, e);
		checks_done++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task rc(input [2:0] ad, input [7:0] e);
		cpu.cyc(ad, 8'h00, 1'b1);
		chk(cpu.q, e);
	endtask
	task rst(input p);
		@(posedge sys_clk_i);
		{rst_i, por_i} <= {1'b1, p};
		repeat (5) @(posedge sys_clk_i);
		{rst_i, por_i} <= 2'b00;
	endtask
	task end_sim;
		if (err_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ====
	// Scenarios
	task t_data;
		cpu.wr(3'h0, 8'h04);
		cpu.go(8'h04);
		rc(3'h0, 8'h04);
		repeat (45) @(posedge sys_clk_i);
		cpu.wr(3'h4, 8'hA5);
		cpu.wr(3'h2, 8'h3C);
		cpu.go(8'h04);
		cpu.wr(3'h0, 8'h00);
		rc(3'h0, 8'h02);
		repeat (9) @(posedge sys_clk_i);
		rc(3'h6, 8'h10);
		cpu.wr(3'h6, 8'h00);
		rc(3'h6, 8'h00);
		cpu.wr(3'h2, 8'h00);
		cpu.wr(3'h0, 8'h01);
		rc(3'h2, 8'h3C);
	endtask
	task t_ref;
		cpu.wr(3'h0, 8'h04);
		cpu.wr(3'h1, 8'h55);
		cpu.wr(3'h2, 8'h11);
		cpu.wr(3'h1, 8'hAA);
		cpu.wr(3'h0, 8'h06);
		rc(3'h0, 8'h04);
		rc(3'h1, 8'h00);
		cpu.wr(3'h0, 8'h00);
		cpu.go(8'h00);
		rc(3'h0, 8'h00);
		cpu.wr(3'h0, 8'h44);
		cpu.go(8'h44);
		rc(3'h0, 8'h44);
	endtask
	task t_prog;
		@(posedge sys_clk_i);
		swp <= 2'b00;
		cpu.wr(3'h5, 8'h12);
		cpu.wr(3'h3, 8'hFF);
		cpu.wr(3'h2, 8'hA5);
		cpu.wr(3'h0, 8'h84);
		cpu.go(8'h84);
		rc(3'h0, 8'h84);
		@(posedge sys_clk_i);
		swp <= 2'b01;
		cpu.go(8'h84);
		repeat (9) @(posedge sys_clk_i);
		cpu.wr(3'h2, 8'h00);
		cpu.wr(3'h3, 8'h00);
		cpu.wr(3'h0, 8'h81);
		repeat (2) @(posedge sys_clk_i);
		rc(3'h2, 8'hA5);
		rc(3'h3, 8'h3F);
		rc(3'h0, 8'h80);
	endtask
	task t_abt;
		cpu.wr(3'h0, 8'h04);
		cpu.go(8'h04);
		@(posedge sys_clk_i);
		rst_i <= 1'b1;
		@(posedge sys_clk_i);
		rst_i <= 1'b0;
		#1 chk({7'h00, busy}, 8'h00);
		rc(3'h0, 8'h0C);
		rst(1'b1);
		rc(3'h0, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			@(posedge sys_clk_i);
			req <= 1'b1;
			{dpn, ppn} <= k[1:0];
			repeat (2) @(posedge sys_clk_i);
			#1 chk({7'h00, pblk}, {7'h00, k != 3});
		end
	endtask
	initial
	begin
		{rst_i, por_i, req, dpn, ppn} = 5'b11000;
		swp = 2'b01;
		err_count = 0;
		checks_done = 0;
		rst(1'b1);
		t_data;
		t_ref;
		t_prog;
		t_abt;
		end_sim;
	end
	initial
	begin
		#30000;
		err_count++;
		end_sim;
	end
endmodule
